// ---- lis_top.sv ----
// How it works
// RULE1 - First request codes 0-2, 6-B and F keep both axes inactive.
// RULE2 - Code 3: active while terminal 6 (A) or 12 (B) closed.
// RULE3 - Code 4: active while terminal 7 (A) or 13 (B) closed.
// RULE4 - Code 5: active while terminal 8 (A) or 14 (B) closed.
// RULE5 - Code C: axis A active while terminal 6 open.
// RULE6 - Code D: active while terminal 7 (A) or 13 (B) open.
// RULE7 - Code E: axis A active while terminal 8 open.
// RULE8 - Second request decodes every code exactly like the first.
// RULE9 - Third request decodes codes up to E like the first.
// RULE10 - Code C: axis B active while terminal 12 open.
// RULE11 - Code E: axis B active while terminal 14 open.
// RULE12 - Third request code F keeps both axes inactive.
// RULE13 - Terminals pass two flops before decode; requests are registered.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lis_top #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] connTermA,
  input wire logic [2:0] connTermB,
  input wire lis_pkg::lis_axi_req_type axiReq,
  output lis_pkg::lis_axi_rsp_type axiRsp,
  output logic [2:0] latchReqA,
  output logic [2:0] latchReqB
);

  // Map is decoded on eight address bits
  if (ADDR_W != 8) begin : g_chk
    $error("lis_top: ADDR_W must be 8");
  end

  typedef struct packed {
    logic [2:0] syncA1;
    logic [2:0] syncA2;
    logic [2:0] syncB1;
    logic [2:0] syncB2;
    logic [11:0] sel;
    logic [2:0] latchA;
    logic [2:0] latchB;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    lis_pkg::lis_axi_rsp_type rsp;
  } lis_state_type;

  lis_state_type st_q;
  lis_state_type st_d;

  // Decode one code against the three terminals of one axis
  function automatic logic lis_decode(
    input logic [3:0] code,
    input logic [2:0] term
  );
    logic r;
    r = 1'b0;
    if (code >= lis_pkg::LIS_CODE_CLOSED_FIRST &&
        code <= lis_pkg::LIS_CODE_CLOSED_LAST) begin // see RULE2
      r = term[2'(code - lis_pkg::LIS_CODE_CLOSED_FIRST)]; // see RULE3
    end else if (code >= lis_pkg::LIS_CODE_OPEN_FIRST &&
                 code <= lis_pkg::LIS_CODE_OPEN_LAST) begin // see RULE5
      r = ~term[2'(code - lis_pkg::LIS_CODE_OPEN_FIRST)]; // see RULE6
    end
    // All other codes, F included, leave r low: see RULE1
    return r;
  endfunction

  // Read data mux; unmapped addresses answer an error
  function automatic logic [31:0] lis_read(input lis_state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[lis_pkg::LIS_STAT_TERM_A_LSB +: 3] = s.syncA2;
    v[lis_pkg::LIS_STAT_TERM_B_LSB +: 3] = s.syncB2;
    v[lis_pkg::LIS_STAT_REQ_A_LSB +: 3] = s.latchA;
    v[lis_pkg::LIS_STAT_REQ_B_LSB +: 3] = s.latchB;
    return v;
  endfunction

  // Next state: synchronisers, decode, register slave
  always_comb begin
    logic [3:0] code;
    code = 4'h0;
    st_d = st_q;
    // First flop feeds only the second; decode reads the second
    st_d.syncA1 = connTermA; // see RULE13
    st_d.syncA2 = st_q.syncA1;
    st_d.syncB1 = connTermB;
    st_d.syncB2 = st_q.syncB1;
    // Same decoder for all three requests keeps them identical
    for (int i = 0; i < 3; i++) begin
      code = st_q.sel[i*lis_pkg::LIS_CODE_W +: lis_pkg::LIS_CODE_W];
      st_d.latchA[i] = lis_decode(code, st_q.syncA2); // see RULE8
      st_d.latchB[i] = lis_decode(code, st_q.syncB2); // see RULE9
    end
    // Write address and data are taken in either order
    if (axiReq.awvalid && st_q.rsp.awready) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = axiReq.awaddr;
      st_d.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && st_q.rsp.wready) begin
      st_d.wHeld = 1'b1;
      st_d.wData = axiReq.wdata;
      st_d.wStrb = axiReq.wstrb;
      st_d.rsp.wready = 1'b0;
    end
    if (st_q.awHeld && st_q.wHeld && !st_q.rsp.bvalid) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = lis_pkg::LIS_RESP_OKAY;
      if (st_q.awAddr == lis_pkg::LIS_SEL_OFS) begin
        if (st_q.wStrb[0]) begin
          st_d.sel[7:0] = st_q.wData[7:0];
        end
        if (st_q.wStrb[1]) begin
          st_d.sel[11:8] = st_q.wData[11:8];
        end
      end else if (st_q.awAddr != lis_pkg::LIS_STAT_OFS) begin
        st_d.rsp.bresp = lis_pkg::LIS_RESP_SLVERR;
      end
    end
    // Ready comes back only once the response is accepted
    if (st_q.rsp.bvalid && axiReq.bready) begin
      st_d.rsp.bvalid = 1'b0;
      st_d.rsp.awready = 1'b1;
      st_d.rsp.wready = 1'b1;
    end
    // Read answers on the same edge that accepts the address
    if (axiReq.arvalid && st_q.rsp.arready) begin
      st_d.rsp.arready = 1'b0;
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rresp = lis_pkg::LIS_RESP_OKAY;
      st_d.rsp.rdata = 32'h0000_0000;
      if (axiReq.araddr == lis_pkg::LIS_SEL_OFS) begin
        st_d.rsp.rdata[11:0] = st_q.sel;
      end else if (axiReq.araddr == lis_pkg::LIS_STAT_OFS) begin
        st_d.rsp.rdata = lis_read(st_q);
      end else begin
        st_d.rsp.rresp = lis_pkg::LIS_RESP_SLVERR;
      end
    end
    if (st_q.rsp.rvalid && axiReq.rready) begin
      st_d.rsp.rvalid = 1'b0;
      st_d.rsp.arready = 1'b1;
    end
  end

  // Synchronous reset to constants only
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.sel <= lis_pkg::LIS_SEL_RESET;
      st_q.rsp.awready <= 1'b1;
      st_q.rsp.wready <= 1'b1;
      st_q.rsp.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign axiRsp = st_q.rsp;
  assign latchReqA = st_q.latchA;
  assign latchReqB = st_q.latchB;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  wire [3:0] selOne = st_q.sel[3:0];
  wire [3:0] selTwo = st_q.sel[7:4];
  wire [3:0] selThree = st_q.sel[11:8];

  property p_rule1;
    (selOne <= 4'h2 || (selOne >= 4'h6 && selOne <= 4'hb) ||
     selOne == 4'hf) |=> (!st_q.latchA[0] && !st_q.latchB[0]);
  endproperty
  a_rule1: assert property (p_rule1) // see RULE1
    else $error("first request not held inactive");

  property p_rule2;
    selOne == 4'h3 |=> (st_q.latchA[0] == $past(st_q.syncA2[0]) &&
                        st_q.latchB[0] == $past(st_q.syncB2[0]));
  endproperty
  a_rule2: assert property (p_rule2) // see RULE2
    else $error("code 3 does not follow terminals 6 and 12");

  property p_rule3;
    selOne == 4'h4 |=> (st_q.latchA[0] == $past(st_q.syncA2[1]) &&
                        st_q.latchB[0] == $past(st_q.syncB2[1]));
  endproperty
  a_rule3: assert property (p_rule3) // see RULE3
    else $error("code 4 does not follow terminals 7 and 13");

  property p_rule4;
    selOne == 4'h5 |=> (st_q.latchA[0] == $past(st_q.syncA2[2]) &&
                        st_q.latchB[0] == $past(st_q.syncB2[2]));
  endproperty
  a_rule4: assert property (p_rule4) // see RULE4
    else $error("code 5 does not follow terminals 8 and 14");

  property p_rule5;
    selOne == 4'hc |=> st_q.latchA[0] == !$past(st_q.syncA2[0]);
  endproperty
  a_rule5: assert property (p_rule5) // see RULE5
    else $error("code C axis A not inverted terminal 6");

  property p_rule6;
    selOne == 4'hd |=> (st_q.latchA[0] == !$past(st_q.syncA2[1]) &&
                        st_q.latchB[0] == !$past(st_q.syncB2[1]));
  endproperty
  a_rule6: assert property (p_rule6) // see RULE6
    else $error("code D not inverted terminals 7 and 13");

  property p_rule7;
    selOne == 4'he |=> st_q.latchA[0] == !$past(st_q.syncA2[2]);
  endproperty
  a_rule7: assert property (p_rule7) // see RULE7
    else $error("code E axis A not inverted terminal 8");

  property p_rule8;
    selTwo == selOne |=> (st_q.latchA[1] == st_q.latchA[0] &&
                          st_q.latchB[1] == st_q.latchB[0]);
  endproperty
  a_rule8: assert property (p_rule8) // see RULE8
    else $error("second request decodes unlike the first");

  property p_rule9;
    (selThree == selOne && selOne != 4'hf) |=>
      (st_q.latchA[2] == st_q.latchA[0] &&
       st_q.latchB[2] == st_q.latchB[0]);
  endproperty
  a_rule9: assert property (p_rule9) // see RULE9
    else $error("third request decodes unlike the first");

  property p_rule10;
    selOne == 4'hc |=> st_q.latchB[0] == !$past(st_q.syncB2[0]);
  endproperty
  a_rule10: assert property (p_rule10) // see RULE10
    else $error("code C axis B not inverted terminal 12");

  property p_rule11;
    selOne == 4'he |=> st_q.latchB[0] == !$past(st_q.syncB2[2]);
  endproperty
  a_rule11: assert property (p_rule11) // see RULE11
    else $error("code E axis B not inverted terminal 14");

  property p_rule12;
    selThree == 4'hf |=> (!st_q.latchA[2] && !st_q.latchB[2]);
  endproperty
  a_rule12: assert property (p_rule12) // see RULE12
    else $error("third request code F not inactive");

  // Terminal held for three edges reaches the second stage
  sequence s_termHeld;
    $stable(connTermA) [*3];
  endsequence
  sequence s_termSeen;
    st_q.syncA2 == $past(connTermA, 2);
  endsequence
  property p_rule13;
    s_termHeld |-> s_termSeen;
  endproperty
  a_rule13: assert property (p_rule13) // see RULE13
    else $error("synchroniser depth is not two");

endmodule
`default_nettype wire

// ---- lis_pkg.sv ----
package lis_pkg;
  // Register map, byte addresses on the AXI4-Lite port
  localparam logic [7:0] LIS_SEL_OFS = 8'h00;
  localparam logic [7:0] LIS_STAT_OFS = 8'h04;
  // Selector fields in the select register
  localparam int LIS_CODE_W = 4;
  localparam int LIS_SEL_ONE_LSB = 0;
  localparam int LIS_SEL_TWO_LSB = 4;
  localparam int LIS_SEL_THREE_LSB = 8;
  localparam logic [11:0] LIS_SEL_RESET = 12'h000;
  // Status fields
  localparam int LIS_STAT_TERM_A_LSB = 0;
  localparam int LIS_STAT_TERM_B_LSB = 3;
  localparam int LIS_STAT_REQ_A_LSB = 8;
  localparam int LIS_STAT_REQ_B_LSB = 11;
  // Selector codes: three terminals closed, then the same three open
  localparam logic [3:0] LIS_CODE_CLOSED_FIRST = 4'h3;
  localparam logic [3:0] LIS_CODE_CLOSED_LAST = 4'h5;
  localparam logic [3:0] LIS_CODE_OPEN_FIRST = 4'hc;
  localparam logic [3:0] LIS_CODE_OPEN_LAST = 4'he;
  localparam logic [3:0] LIS_CODE_OFF = 4'hf;
  // AXI responses
  localparam logic [1:0] LIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] LIS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } lis_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } lis_axi_rsp_type;
endpackage

// ---- lis_contact_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lis_contact_model (
  input wire logic mclk,
  input wire logic [5:0] setClosed,
  output var logic [2:0] termA = 3'h0,
  output var logic [2:0] termB = 3'h0
);
  // Contacts settle one edge after being thrown; 1 means closed.
  // No bounce is modelled, so the selector is judged on clean levels.
  always @(posedge mclk) begin
    termA <= setClosed[2:0];
    termB <= setClosed[5:3];
  end
endmodule
`default_nettype wire

// ---- tb_latch_input_selector.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_latch_input_selector;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] contacts = 6'h00;
  logic [2:0] termA, termB, latchReqA, latchReqB, eA, eB;
  lis_pkg::lis_axi_req_type axiReq = '0;
  lis_pkg::lis_axi_rsp_type axiRsp;
  int fails = 0;
  int samplesChecked = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [3:0] c1, c2, c3;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  lis_contact_model contactModel (.mclk(mclk), .setClosed(contacts),
    .termA(termA), .termB(termB));

  lis_top dut (.mclk(mclk), .rst_b(rst_b), .connTermA(termA),
    .connTermB(termB), .axiReq(axiReq), .axiRsp(axiRsp),
    .latchReqA(latchReqA), .latchReqB(latchReqB));

  // Decode expected from the code table, independent of the design
  function automatic logic expBit(input logic [3:0] c, input logic [2:0] t);
    if (c >= 4'h3 && c <= 4'h5) return t[c - 4'h3];
    if (c >= 4'hc && c <= 4'he) return ~t[c - 4'hc];
    return 1'b0;
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data offered together; bready held until bvalid
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge mclk);
    axiReq.awaddr <= a;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= s;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge mclk);
      n++;
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        resp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) check("write answer", 32'h0, 32'h1);
  endtask

  task automatic axiRead(input logic [7:0] a);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge mclk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge mclk);
      n++;
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        resp = axiRsp.rresp;
        rd = axiRsp.rdata;
        axiReq.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) check("read answer", 32'h0, 32'h1);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Every code on each selector, each with all eight contact patterns
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    axiRead(lis_pkg::LIS_SEL_OFS);
    check("sel reset", rd, {20'h0, lis_pkg::LIS_SEL_RESET});
    for (int c = 0; c < 16; c++) begin
      c1 = 4'(c);
      c2 = c1 + 4'h5;
      c3 = c1 + 4'ha;
      axiWrite(lis_pkg::LIS_SEL_OFS, {20'h0, c3, c2, c1}, 4'h3);
      check("sel bresp", 32'(resp), 32'(lis_pkg::LIS_RESP_OKAY));
      for (int p = 0; p < 8; p++) begin
        contacts <= {~3'(p), 3'(p)};
        repeat (6) @(posedge mclk);
        eA = {expBit(c3, 3'(p)), expBit(c2, 3'(p)), expBit(c1, 3'(p))};
        eB = {expBit(c3, ~3'(p)), expBit(c2, ~3'(p)), expBit(c1, ~3'(p))};
        check("latchReqA", 32'(latchReqA), 32'(eA));
        check("latchReqB", 32'(latchReqB), 32'(eB));
      end
      axiRead(lis_pkg::LIS_STAT_OFS);
      check("status", 32'({rd[13:8], rd[5:0]}), 32'({eB, eA, 6'h07}));
    end
    $display("test decode done");
    // Byte strobe: only the low byte of the selector changes
    axiWrite(lis_pkg::LIS_SEL_OFS, 32'h00000fff, 4'h1);
    axiRead(lis_pkg::LIS_SEL_OFS);
    check("sel strobe", rd, {20'h0, c3, 8'hff});
    // Unmapped place and read-only status leave the selector alone
    axiWrite(8'h10, 32'h00000333, 4'h3);
    check("unmapped bresp", 32'(resp), 32'(lis_pkg::LIS_RESP_SLVERR));
    axiRead(8'h10);
    check("unmapped rresp", 32'(resp), 32'(lis_pkg::LIS_RESP_SLVERR));
    check("unmapped rdata", rd, 32'h0);
    axiWrite(lis_pkg::LIS_STAT_OFS, 32'h00000333, 4'h3);
    check("status bresp", 32'(resp), 32'(lis_pkg::LIS_RESP_OKAY));
    axiRead(lis_pkg::LIS_SEL_OFS);
    check("sel kept", rd, {20'h0, c3, 8'hff});
    $display("test register access done");
    stop_test();
  end

  // Whole run needs about 900 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
